// >>> hdl/eip_pkg.sv
// constants for the external interrupt edge select and priority block
package eip_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_TIMER_CTRL    = 8'h88;
  localparam logic [7:0] ADDR_EXT_ENABLE    = 8'ha8;
  localparam logic [7:0] ADDR_INT_ENABLE1   = 8'ha9;
  localparam logic [7:0] ADDR_INT_ENABLE2   = 8'haa;
  localparam logic [7:0] ADDR_G0_FALL_MASK  = 8'hb4;
  localparam logic [7:0] ADDR_EXT_PRIORITY  = 8'hb8;
  localparam logic [7:0] ADDR_PRIORITY1     = 8'hb9;
  localparam logic [7:0] ADDR_SERIAL_PRIO2  = 8'hba;
  localparam logic [7:0] ADDR_G0_RISE_MASK  = 8'hbb;
  localparam logic [7:0] ADDR_G1_FALL_MASK  = 8'hbc;
  localparam logic [7:0] ADDR_G1_RISE_MASK  = 8'hbd;
  localparam logic [7:0] ADDR_G2_FALL_MASK  = 8'hbe;
  localparam logic [7:0] ADDR_G2_RISE_MASK  = 8'hbf;
  localparam logic [7:0] ADDR_EVENT_STATUS  = 8'hc0;
  localparam logic [7:0] ADDR_EVENT_MASK    = 8'hc1;

  // reset value and writable-bit masks
  localparam logic [7:0] REG_RESET          = 8'h00;
  localparam logic [7:0] WMASK_G0_MASK      = 8'hf0;
  localparam logic [7:0] WMASK_G2_MASK      = 8'h0f;
  localparam logic [7:0] WMASK_SERIAL       = 8'h1f;
  localparam logic [7:0] WMASK_EVENT        = 8'h07;

  // field positions
  localparam int TIMER_AND_EXT_IRQ_CONTROL_G1_FLAG   = 3;
  localparam int TIMER_AND_EXT_IRQ_CONTROL_G0_FLAG   = 1;
  localparam int EXT_EN_G0      = 0;
  localparam int EXT_EN_G1      = 2;
  localparam int EXT_PRIO_G0    = 0;
  localparam int EXT_PRIO_G1    = 2;
  localparam int IEN1_G2_BIT    = 3;
  localparam int PRIO1_G2_BIT   = 3;
  localparam int STAT_G0        = 0;
  localparam int STAT_G1        = 1;
  localparam int STAT_G2        = 2;
  localparam int G0_FIRST_PIN   = 4;

  // widths and source numbering; lower source number wins within a level
  localparam int G0_PINS        = 4;
  localparam int G1_PINS        = 8;
  localparam int G2_PINS        = 4;
  localparam int N_SERIAL       = 5;
  localparam int N_SRC          = 8;
  localparam int SRC_W          = 3;
  localparam logic [2:0] SRC_G0   = 3'h0;
  localparam logic [2:0] SRC_G1   = 3'h1;
  localparam logic [2:0] SRC_G2   = 3'h2;
  localparam int SRC_SER_FIRST  = 3;
endpackage

// >>> hdl/eip_ifs.sv
// interfaces between the edge detectors, the arbiter and the top
`timescale 1ns/100ps
interface eip_edge_if #(parameter int N = 4);
  logic [N-1:0] rise_en;
  logic [N-1:0] fall_en;
  logic         hit;
  modport ctl (output rise_en, output fall_en, input hit);
  modport det (input rise_en, input fall_en, output hit);
endinterface // eip_edge_if

interface eip_arb_if;
  logic [7:0] req;
  logic [7:0] high;
  logic       ack;
  logic       ack_high;
  logic       reti;
  logic       grant_valid;
  logic [2:0] grant_id;
  logic       grant_high;
  logic       in_hi;
  logic       in_lo;
  modport ctl (output req, output high, output ack, output ack_high, output reti,
               input grant_valid, input grant_id, input grant_high, input in_hi, input in_lo);
  modport arb (input req, input high, input ack, input ack_high, input reti,
               output grant_valid, output grant_id, output grant_high, output in_hi,
               output in_lo);
endinterface // eip_arb_if

// >>> hdl/eip_edge_detect.sv
// synchronised per-pin edge detector with rising and falling enables
`timescale 1ns/100ps
module eip_edge_detect #(
  parameter int N = 4
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // pins
  input  wire logic [N-1:0] pin,
  // enables and event
  eip_edge_if.det           edge_port
);
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  logic [N-1:0] prev;
  logic [N-1:0] next_prev;
  logic [N-1:0] fire;

  // pins are asynchronous: two flops before any logic looks at them
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      prev  <= next_prev;
    end
  end

  always_comb begin
    next_prev = sync2;
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      // both enables set means either edge counts
      assign fire[i] = (edge_port.rise_en[i] & sync2[i] & ~prev[i]) |
                       (edge_port.fall_en[i] & ~sync2[i] & prev[i]);
    end
  endgenerate

  assign edge_port.hit = |fire;
endmodule // eip_edge_detect

// >>> hdl/eip_prio_arb.sv
// two-level priority picker with in-service tracking for nesting
`timescale 1ns/100ps
module eip_prio_arb (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // requests and grant
  eip_arb_if.arb    arb_port
);
  logic in_hi;
  logic in_lo;
  logic next_in_hi;
  logic next_in_lo;
  logic [7:0] hi_req;
  logic [7:0] lo_req;

  assign hi_req = arb_port.req & arb_port.high;
  assign lo_req = arb_port.req & ~arb_port.high;

  // high level always beats low; high may preempt a low routine, never another high
  always_comb begin
    arb_port.grant_valid = 1'b0;
    arb_port.grant_id    = 3'h0;
    arb_port.grant_high  = 1'b0;
    if (!in_hi && (hi_req != 8'h00)) begin
      arb_port.grant_valid = 1'b1;
      arb_port.grant_high  = 1'b1;
      for (int k = 7; k >= 0; k--) begin
        if (hi_req[k]) begin
          arb_port.grant_id = k[2:0];
        end
      end
    end else if (!in_hi && !in_lo && (lo_req != 8'h00)) begin
      arb_port.grant_valid = 1'b1;
      for (int k = 7; k >= 0; k--) begin
        if (lo_req[k]) begin
          arb_port.grant_id = k[2:0];
        end
      end
    end
  end

  // return from a routine ends the innermost level first
  always_comb begin
    next_in_hi = in_hi;
    next_in_lo = in_lo;
    if (arb_port.reti) begin
      if (in_hi) begin
        next_in_hi = 1'b0;
      end else begin
        next_in_lo = 1'b0;
      end
    end
    if (arb_port.ack) begin
      if (arb_port.ack_high) begin
        next_in_hi = 1'b1;
      end else begin
        next_in_lo = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_hi <= 1'b0;
      in_lo <= 1'b0;
    end else begin
      in_hi <= next_in_hi;
      in_lo <= next_in_lo;
    end
  end

  assign arb_port.in_hi = in_hi;
  assign arb_port.in_lo = in_lo;
endmodule // eip_prio_arb

// >>> hdl/eip_ext_irq.sv
// external interrupt edge select, request flags and two-level priority top
`timescale 1ns/100ps
module eip_ext_irq (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [7:0]                    reg_rdata,
  // external pins
  input  wire logic [eip_pkg::G0_PINS-1:0]   ext_group0,
  input  wire logic [eip_pkg::G1_PINS-1:0]   ext_group1,
  input  wire logic [eip_pkg::G2_PINS-1:0]   ext_group2,
  // serial port requests, same clock
  input  wire logic [eip_pkg::N_SERIAL-1:0]  serial_req,
  // cpu interrupt response
  output logic                               cpu_irq_req,
  output logic      [eip_pkg::SRC_W-1:0]     cpu_irq_id,
  output logic                               cpu_irq_high,
  input  wire logic                          cpu_ack,
  input  wire logic                          cpu_reti,
  // event interrupt
  output logic                               irq
);
  // software-visible registers and flags, and the hidden group2 pending bit
  logic [7:0] g0_fall_mask;
  logic [7:0] g0_rise_mask;
  logic [7:0] g1_fall_mask;
  logic [7:0] g1_rise_mask;
  logic [7:0] g2_fall_mask;
  logic [7:0] g2_rise_mask;
  logic [7:0] serial_prio2;
  logic [7:0] prio1;
  logic [7:0] int_enable1;
  logic [7:0] int_enable2;
  logic [7:0] ext_enable;
  logic [7:0] ext_prio;
  logic [7:0] ev_status;
  logic [7:0] ev_mask;
  logic       g0_flag;
  logic       g1_flag;
  logic       g2_pend;
  // next values
  logic [7:0] next_g0_fall_mask;
  logic [7:0] next_g0_rise_mask;
  logic [7:0] next_g1_fall_mask;
  logic [7:0] next_g1_rise_mask;
  logic [7:0] next_g2_fall_mask;
  logic [7:0] next_g2_rise_mask;
  logic [7:0] next_serial_prio2;
  logic [7:0] next_prio1;
  logic [7:0] next_int_enable1;
  logic [7:0] next_int_enable2;
  logic [7:0] next_ext_enable;
  logic [7:0] next_ext_prio;
  logic [7:0] next_ev_status;
  logic [7:0] next_ev_mask;
  logic [7:0] next_reg_rdata;
  logic       next_g0_flag;
  logic       next_g1_flag;
  logic       next_g2_pend;
  logic       next_irq_req;
  logic       next_irq_high;
  logic [2:0] next_irq_id;
  // accept and write decode
  logic       acc;
  logic       acc_g0;
  logic       acc_g1;
  logic       acc_g2;
  logic       wr_timer_and_ext_irq_control;

  eip_edge_if #(.N(eip_pkg::G0_PINS)) g0_if ();
  eip_edge_if #(.N(eip_pkg::G1_PINS)) g1_if ();
  eip_edge_if #(.N(eip_pkg::G2_PINS)) g2_if ();
  eip_arb_if arb_if ();

  assign g0_if.fall_en = g0_fall_mask[7:eip_pkg::G0_FIRST_PIN];
  assign g0_if.rise_en = g0_rise_mask[7:eip_pkg::G0_FIRST_PIN];
  assign g1_if.fall_en = g1_fall_mask;
  assign g1_if.rise_en = g1_rise_mask;
  assign g2_if.fall_en = g2_fall_mask[eip_pkg::G2_PINS-1:0];
  assign g2_if.rise_en = g2_rise_mask[eip_pkg::G2_PINS-1:0];

  eip_edge_detect #(.N(eip_pkg::G0_PINS)) u_g0 (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin       (ext_group0),
    .edge_port (g0_if.det)
  );
  eip_edge_detect #(.N(eip_pkg::G1_PINS)) u_g1 (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin       (ext_group1),
    .edge_port (g1_if.det)
  );
  eip_edge_detect #(.N(eip_pkg::G2_PINS)) u_g2 (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin       (ext_group2),
    .edge_port (g2_if.det)
  );

  // request vector; index order is the fixed order inside a level
  assign arb_if.req[eip_pkg::SRC_G0] = g0_flag & ext_enable[eip_pkg::EXT_EN_G0];
  assign arb_if.req[eip_pkg::SRC_G1] = g1_flag & ext_enable[eip_pkg::EXT_EN_G1];
  assign arb_if.req[eip_pkg::SRC_G2] = g2_pend & int_enable1[eip_pkg::IEN1_G2_BIT];
  assign arb_if.req[7:eip_pkg::SRC_SER_FIRST] =
    serial_req & int_enable2[eip_pkg::N_SERIAL-1:0];
  assign arb_if.high[eip_pkg::SRC_G0] = ext_prio[eip_pkg::EXT_PRIO_G0];
  assign arb_if.high[eip_pkg::SRC_G1] = ext_prio[eip_pkg::EXT_PRIO_G1];
  assign arb_if.high[eip_pkg::SRC_G2] = prio1[eip_pkg::PRIO1_G2_BIT];
  assign arb_if.high[7:eip_pkg::SRC_SER_FIRST] =
    serial_prio2[eip_pkg::N_SERIAL-1:0];

  // an ack only counts while a request is shown
  assign acc          = cpu_ack & cpu_irq_req;
  assign acc_g0       = acc & (cpu_irq_id == eip_pkg::SRC_G0);
  assign acc_g1       = acc & (cpu_irq_id == eip_pkg::SRC_G1);
  assign acc_g2       = acc & (cpu_irq_id == eip_pkg::SRC_G2);
  assign arb_if.ack      = acc;
  assign arb_if.ack_high = cpu_irq_high;
  assign arb_if.reti     = cpu_reti;
  assign wr_timer_and_ext_irq_control         = reg_wr & (reg_addr == eip_pkg::ADDR_TIMER_CTRL);

  eip_prio_arb u_arb (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .arb_port (arb_if.arb)
  );

  // flags: a new edge wins over the accept clear and over a software clear
  always_comb begin
    next_g0_flag = g0_flag;
    next_g1_flag = g1_flag;
    next_g2_pend = g2_pend;
    if (wr_timer_and_ext_irq_control) begin
      next_g0_flag = reg_wdata[eip_pkg::TIMER_AND_EXT_IRQ_CONTROL_G0_FLAG];
      next_g1_flag = reg_wdata[eip_pkg::TIMER_AND_EXT_IRQ_CONTROL_G1_FLAG];
    end
    if (acc_g0) begin
      next_g0_flag = 1'b0;
    end
    if (acc_g1) begin
      next_g1_flag = 1'b0;
    end
    if (acc_g2) begin
      next_g2_pend = 1'b0;
    end
    if (g0_if.hit) begin
      next_g0_flag = 1'b1;
    end
    if (g1_if.hit) begin
      next_g1_flag = 1'b1;
    end
    if (g2_if.hit) begin
      next_g2_pend = 1'b1;
    end
  end

  // register writes
  always_comb begin
    next_g0_fall_mask = g0_fall_mask;
    next_g0_rise_mask = g0_rise_mask;
    next_g1_fall_mask = g1_fall_mask;
    next_g1_rise_mask = g1_rise_mask;
    next_g2_fall_mask = g2_fall_mask;
    next_g2_rise_mask = g2_rise_mask;
    next_serial_prio2 = serial_prio2;
    next_prio1        = prio1;
    next_int_enable1  = int_enable1;
    next_int_enable2  = int_enable2;
    next_ext_enable   = ext_enable;
    next_ext_prio     = ext_prio;
    next_ev_mask      = ev_mask;
    if (reg_wr) begin
      case (reg_addr)
        eip_pkg::ADDR_G0_FALL_MASK: next_g0_fall_mask = reg_wdata & eip_pkg::WMASK_G0_MASK;
        eip_pkg::ADDR_G0_RISE_MASK: next_g0_rise_mask = reg_wdata & eip_pkg::WMASK_G0_MASK;
        eip_pkg::ADDR_G1_FALL_MASK: next_g1_fall_mask = reg_wdata;
        eip_pkg::ADDR_G1_RISE_MASK: next_g1_rise_mask = reg_wdata;
        eip_pkg::ADDR_G2_FALL_MASK: next_g2_fall_mask = reg_wdata & eip_pkg::WMASK_G2_MASK;
        eip_pkg::ADDR_G2_RISE_MASK: next_g2_rise_mask = reg_wdata & eip_pkg::WMASK_G2_MASK;
        eip_pkg::ADDR_SERIAL_PRIO2: next_serial_prio2 = reg_wdata & eip_pkg::WMASK_SERIAL;
        eip_pkg::ADDR_PRIORITY1:    next_prio1        = reg_wdata;
        eip_pkg::ADDR_INT_ENABLE1:  next_int_enable1  = reg_wdata;
        eip_pkg::ADDR_INT_ENABLE2:  next_int_enable2  = reg_wdata & eip_pkg::WMASK_SERIAL;
        eip_pkg::ADDR_EXT_ENABLE:   next_ext_enable   = reg_wdata;
        eip_pkg::ADDR_EXT_PRIORITY: next_ext_prio     = reg_wdata;
        eip_pkg::ADDR_EVENT_MASK:   next_ev_mask      = reg_wdata & eip_pkg::WMASK_EVENT;
        default: ;
      endcase
    end
  end

  // event status: read clears, a same-cycle edge still lands
  always_comb begin
    next_ev_status = ev_status;
    if (reg_rd && (reg_addr == eip_pkg::ADDR_EVENT_STATUS)) begin
      next_ev_status = 8'h00;
    end
    next_ev_status[eip_pkg::STAT_G0] = next_ev_status[eip_pkg::STAT_G0] | g0_if.hit;
    next_ev_status[eip_pkg::STAT_G1] = next_ev_status[eip_pkg::STAT_G1] | g1_if.hit;
    next_ev_status[eip_pkg::STAT_G2] = next_ev_status[eip_pkg::STAT_G2] | g2_if.hit;
  end

  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        eip_pkg::ADDR_TIMER_CTRL: begin
          next_reg_rdata[eip_pkg::TIMER_AND_EXT_IRQ_CONTROL_G1_FLAG] = g1_flag;
          next_reg_rdata[eip_pkg::TIMER_AND_EXT_IRQ_CONTROL_G0_FLAG] = g0_flag;
        end
        eip_pkg::ADDR_G0_FALL_MASK: next_reg_rdata = g0_fall_mask;
        eip_pkg::ADDR_G0_RISE_MASK: next_reg_rdata = g0_rise_mask;
        eip_pkg::ADDR_G1_FALL_MASK: next_reg_rdata = g1_fall_mask;
        eip_pkg::ADDR_G1_RISE_MASK: next_reg_rdata = g1_rise_mask;
        eip_pkg::ADDR_G2_FALL_MASK: next_reg_rdata = g2_fall_mask;
        eip_pkg::ADDR_G2_RISE_MASK: next_reg_rdata = g2_rise_mask;
        eip_pkg::ADDR_SERIAL_PRIO2: next_reg_rdata = serial_prio2;
        eip_pkg::ADDR_PRIORITY1:    next_reg_rdata = prio1;
        eip_pkg::ADDR_INT_ENABLE1:  next_reg_rdata = int_enable1;
        eip_pkg::ADDR_INT_ENABLE2:  next_reg_rdata = int_enable2;
        eip_pkg::ADDR_EXT_ENABLE:   next_reg_rdata = ext_enable;
        eip_pkg::ADDR_EXT_PRIORITY: next_reg_rdata = ext_prio;
        eip_pkg::ADDR_EVENT_STATUS: next_reg_rdata = ev_status;
        eip_pkg::ADDR_EVENT_MASK:   next_reg_rdata = ev_mask;
        default:                    next_reg_rdata = 8'h00;
      endcase
    end
  end

  // the request drops with the ack so the stale grant is never acked twice
  always_comb begin
    next_irq_req  = arb_if.grant_valid & ~acc;
    next_irq_id   = arb_if.grant_id;
    next_irq_high = arb_if.grant_high;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      g0_fall_mask <= eip_pkg::REG_RESET;
      g0_rise_mask <= eip_pkg::REG_RESET;
      g1_fall_mask <= eip_pkg::REG_RESET;
      g1_rise_mask <= eip_pkg::REG_RESET;
      g2_fall_mask <= eip_pkg::REG_RESET;
      g2_rise_mask <= eip_pkg::REG_RESET;
      serial_prio2 <= eip_pkg::REG_RESET;
      prio1        <= eip_pkg::REG_RESET;
      int_enable1  <= eip_pkg::REG_RESET;
      int_enable2  <= eip_pkg::REG_RESET;
      ext_enable   <= eip_pkg::REG_RESET;
      ext_prio     <= eip_pkg::REG_RESET;
      ev_status    <= eip_pkg::REG_RESET;
      ev_mask      <= eip_pkg::REG_RESET;
      reg_rdata    <= eip_pkg::REG_RESET;
      g0_flag      <= 1'b0;
      g1_flag      <= 1'b0;
      g2_pend      <= 1'b0;
      cpu_irq_req  <= 1'b0;
      cpu_irq_id   <= 3'h0;
      cpu_irq_high <= 1'b0;
      irq          <= 1'b0;
    end else begin
      g0_fall_mask <= next_g0_fall_mask;
      g0_rise_mask <= next_g0_rise_mask;
      g1_fall_mask <= next_g1_fall_mask;
      g1_rise_mask <= next_g1_rise_mask;
      g2_fall_mask <= next_g2_fall_mask;
      g2_rise_mask <= next_g2_rise_mask;
      serial_prio2 <= next_serial_prio2;
      prio1        <= next_prio1;
      int_enable1  <= next_int_enable1;
      int_enable2  <= next_int_enable2;
      ext_enable   <= next_ext_enable;
      ext_prio     <= next_ext_prio;
      ev_status    <= next_ev_status;
      ev_mask      <= next_ev_mask;
      reg_rdata    <= next_reg_rdata;
      g0_flag      <= next_g0_flag;
      g1_flag      <= next_g1_flag;
      g2_pend      <= next_g2_pend;
      cpu_irq_req  <= next_irq_req;
      cpu_irq_id   <= next_irq_id;
      cpu_irq_high <= next_irq_high;
      // taken from the next status so irq rises with the bit, not a cycle later
      irq          <= |(next_ev_status & next_ev_mask);
    end
  end
endmodule // eip_ext_irq

// >>> dv/eip_ext_irq_monitor.sv
// assertion checker for the external interrupt edge select and priority top
`timescale 1ns/100ps
module eip_ext_irq_monitor (
  // clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst,
  // register port
  input wire logic [7:0]                reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [7:0]                reg_rdata,
  // cpu response
  input wire logic                      cpu_irq_req,
  input wire logic [eip_pkg::SRC_W-1:0] cpu_irq_id,
  input wire logic                      cpu_irq_high,
  input wire logic                      cpu_ack
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0] g2en_sh;
  logic [7:0] prio_sh;
  logic [7:0] next_g2en_sh;
  logic [7:0] next_prio_sh;
  // shadows of the gate and level registers, seen only through the write port
  always_comb begin
    next_g2en_sh = g2en_sh;
    next_prio_sh = prio_sh;
    if (reg_wr && reg_addr == eip_pkg::ADDR_INT_ENABLE1)
      next_g2en_sh = reg_wdata;
    if (reg_wr && reg_addr == eip_pkg::ADDR_SERIAL_PRIO2)
      next_prio_sh = reg_wdata;
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      g2en_sh <= 8'h00;
      prio_sh <= 8'h00;
    end else begin
      g2en_sh <= next_g2en_sh;
      prio_sh <= next_prio_sh;
    end
  end
  sequence rd_of(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence wr_of(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence
  property wr_then_rd(logic [7:0] a);
    wr_of(a) ##1 rd_of(a) |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
  a_flag_reserved: assert property (rd_of(eip_pkg::ADDR_TIMER_CTRL) |=> (reg_rdata & 8'hf5) == 8'h00)
    else $error("timer control shows bits beyond the two flags");
  a_g0f_reserved: assert property (rd_of(eip_pkg::ADDR_G0_FALL_MASK) |=> reg_rdata[3:0] == 4'h0)
    else $error("group0 falling mask low nibble not zero");
  a_g0r_reserved: assert property (rd_of(eip_pkg::ADDR_G0_RISE_MASK) |=> reg_rdata[3:0] == 4'h0)
    else $error("group0 rising mask low nibble not zero");
  a_g2f_reserved: assert property (rd_of(eip_pkg::ADDR_G2_FALL_MASK) |=> reg_rdata[7:4] == 4'h0)
    else $error("group2 falling mask high nibble not zero");
  a_prio_reserved: assert property (rd_of(eip_pkg::ADDR_SERIAL_PRIO2) |=> reg_rdata[7:5] == 3'h0)
    else $error("serial priority upper bits not zero");
  a_g1f_readback: assert property (wr_then_rd(eip_pkg::ADDR_G1_FALL_MASK))
    else $error("group1 falling mask readback wrong");
  a_g1r_readback: assert property (wr_then_rd(eip_pkg::ADDR_G1_RISE_MASK))
    else $error("group1 rising mask readback wrong");
  a_ack_drops_req: assert property (cpu_irq_req && cpu_ack |=> !cpu_irq_req)
    else $error("offer still up after acceptance");
  a_g2_gated: assert property (cpu_irq_req && cpu_irq_id == eip_pkg::SRC_G2 |->
    g2en_sh[3] || $past(g2en_sh[3]) || $past(g2en_sh[3], 2))
    else $error("group2 offered with its enable clear");
  a_serial_level: assert property (cpu_irq_req && cpu_irq_id >= 3'h3 && prio_sh == $past(prio_sh, 2)
    |-> cpu_irq_high == prio_sh[cpu_irq_id - 3'h3])
    else $error("serial offer level differs from its priority bit");
endmodule // eip_ext_irq_monitor

bind eip_ext_irq eip_ext_irq_monitor u_eip_ext_irq_monitor (.clk_sys, .rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_irq_req, .cpu_irq_id, .cpu_irq_high, .cpu_ack);

// >>> dv/eip_cpu_model.sv
// cpu interrupt response model: accepts offers promptly or slowly, returns on command
`timescale 1ns/100ps
module eip_cpu_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // offer from the block
  input  wire logic       cpu_irq_req,
  input  wire logic [2:0] cpu_irq_id,
  input  wire logic       cpu_irq_high,
  // bench control
  input  wire logic       accept_en,
  input  wire logic       slow,
  input  wire logic       reti_cmd,
  // response and record
  output logic            cpu_ack,
  output logic            cpu_reti,
  output logic [2:0]      got_id,
  output logic            got_high,
  output logic [7:0]      got_cnt
);
  logic [1:0] wait_cnt;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {cpu_ack, cpu_reti, got_id, got_high, got_cnt, wait_cnt} <= '0;
    end else begin
      cpu_reti <= reti_cmd;
      cpu_ack <= 1'b0;
      wait_cnt <= 2'h0;
      // record what was really on offer at the accepting edge
      if (cpu_ack && cpu_irq_req) begin
        got_id <= cpu_irq_id;
        got_high <= cpu_irq_high;
        got_cnt <= got_cnt + 8'h01;
      end
      // one-cycle accept only while an offer stands
      if (cpu_irq_req && !cpu_ack && accept_en) begin
        wait_cnt <= wait_cnt + 2'h1;
        if (!slow || wait_cnt == 2'h3)
          cpu_ack <= 1'b1;
      end
    end
  end
endmodule // eip_cpu_model

// >>> dv/eip_ext_irq_tb.sv
// self-checking bench for the external interrupt edge select and priority top
`timescale 1ns/100ps
module eip_ext_irq_tb;
  logic       clk_sys, rst, reg_wr, reg_rd, accept_en, slow, reti_cmd;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, got_cnt, ext_group1;
  logic [3:0] ext_group0, ext_group2;
  logic [4:0] serial_req;
  logic [2:0] cpu_irq_id, got_id;
  logic       cpu_irq_req, cpu_irq_high, cpu_ack, cpu_reti, irq, got_high;
  int         n_mismatch, n_checks;

  eip_ext_irq u_eip_ext_irq (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_group0, .ext_group1, .ext_group2, .serial_req, .cpu_irq_req,
    .cpu_irq_id, .cpu_irq_high, .cpu_ack, .cpu_reti, .irq);
  eip_cpu_model u_eip_cpu_model (.clk_sys, .rst, .cpu_irq_req, .cpu_irq_id, .cpu_irq_high,
    .accept_en, .slow, .reti_cmd, .cpu_ack, .cpu_reti, .got_id, .got_high, .got_cnt);

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // write and read back to back, so the readback sees no idle cycle between
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    wr(a, d);
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic wait_offer(input logic [2:0] id, input logic high);
    int i;
    #1;
    for (i = 0; i < 40 && !(cpu_irq_req === 1'b1 && cpu_irq_id === id); i++)
      @(posedge clk_sys) #1;
    chk({4'h0, cpu_irq_high, cpu_irq_id}, {4'h0, high, id});
    if (i == 40) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic accept(input logic [7:0] n);
    int i;
    accept_en <= 1'b1;
    for (i = 0; i < 40 && got_cnt !== n; i++)
      @(posedge clk_sys) #1;
    accept_en <= 1'b0;
    chk(got_cnt, n);
    if (i == 40) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic reti();
    @(posedge clk_sys);
    reti_cmd <= 1'b1;
    @(posedge clk_sys);
    reti_cmd <= 1'b0;
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  task automatic s_reset();
    logic [7:0] al[14] = '{8'h88, 8'hb4, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf,
                           8'ha8, 8'ha9, 8'haa, 8'hc0, 8'hc1, 8'h80};
    foreach (al[i]) rd_chk(al[i], 8'h00);
  endtask
  task automatic s_regs();
    logic [7:0] al[10] = '{8'hb4, 8'hbb, 8'hbc, 8'hbd, 8'hbe, 8'hbf, 8'hba, 8'haa, 8'h88, 8'h80};
    logic [7:0] ml[10] = '{8'hf0, 8'hf0, 8'hff, 8'hff, 8'h0f, 8'h0f, 8'h1f, 8'h1f, 8'h0a, 8'h00};
    foreach (al[i]) wr_rd(al[i], 8'hff, ml[i]);
    foreach (al[i]) wr_rd(al[i], 8'h00, 8'h00);
  endtask
  task automatic s_edges();
    wr(eip_pkg::ADDR_EXT_ENABLE, 8'h05);
    wr(8'hbc, 8'h80);
    ext_group1 <= 8'h80;
    settle();
    rd_chk(8'h88, 8'h00);
    @(posedge clk_sys);
    ext_group1 <= 8'h00;
    settle();
    rd_chk(8'h88, 8'h08);
    wait_offer(eip_pkg::SRC_G1, 1'b0);
    accept(8'h01);
    rd_chk(8'h88, 8'h00);
    reti();
    wr(8'hbc, 8'h00);
    wr(8'hbd, 8'h01);
    ext_group1 <= 8'h01;
    settle();
    rd_chk(8'h88, 8'h08);
    wr(8'h88, 8'h00);
    ext_group1 <= 8'h00;
    settle();
    rd_chk(8'h88, 8'h00);
    wr(8'hb4, 8'h10);
    wr(8'hbb, 8'h10);
    ext_group0 <= 4'h1;
    settle();
    rd_chk(8'h88, 8'h02);
    wr(8'h88, 8'h00);
    ext_group0 <= 4'h0;
    settle();
    rd_chk(8'h88, 8'h02);
    wr(8'h88, 8'h00);
    wr(8'hbf, 8'h08);
    ext_group2 <= 4'h8;
    settle();
    chk({7'h00, cpu_irq_req}, 8'h00);
    wr(eip_pkg::ADDR_INT_ENABLE1, 8'h08);
    wait_offer(eip_pkg::SRC_G2, 1'b0);
    slow <= 1'b1;
    accept(8'h02);
    reti();
    ext_group2 <= 4'h0;
  endtask
  task automatic s_prio();
    wr(8'hba, 8'h02);
    wr(8'haa, 8'h01);
    serial_req <= 5'h03;
    wait_offer(3'h3, 1'b0);
    wr(8'haa, 8'h03);
    wait_offer(3'h4, 1'b1);
    accept(8'h03);
    chk({5'h00, got_id}, 8'h04);
    @(posedge clk_sys);
    serial_req <= 5'h01;
    settle();
    chk({7'h00, cpu_irq_req}, 8'h00);
    reti();
    wait_offer(3'h3, 1'b0);
    accept(8'h04);
    @(posedge clk_sys);
    serial_req <= 5'h03;
    wait_offer(3'h4, 1'b1);
    accept(8'h05);
    @(posedge clk_sys);
    serial_req <= 5'h00;
    reti();
    reti();
  endtask
  task automatic s_irq();
    chk({7'h00, irq}, 8'h00);
    rd_chk(eip_pkg::ADDR_EVENT_STATUS, 8'h07);
    wr(eip_pkg::ADDR_EVENT_MASK, 8'h02);
    // the rising enable of pin 0 is still set from the edge scenario
    wr(8'hbd, 8'h00);
    wr(8'hbc, 8'h01);
    ext_group1 <= 8'h01;
    settle();
    chk({7'h00, irq}, 8'h00);
    @(posedge clk_sys);
    ext_group1 <= 8'h00;
    settle();
    chk({7'h00, irq}, 8'h01);
    rd_chk(eip_pkg::ADDR_EVENT_STATUS, 8'h02);
    settle();
    chk({7'h00, irq}, 8'h00);
    wr(8'h88, 8'h00);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, accept_en, slow, reti_cmd, reg_addr, reg_wdata} = '0;
    {ext_group0, ext_group1, ext_group2, serial_req} = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    s_reset();
    s_regs();
    s_edges();
    s_prio();
    s_irq();
    final_report();
  end
endmodule // eip_ext_irq_tb
